// [shared/cio_pkg.sv]
// Package: register map, modes, selection codes and timing of contact I/O.
//----------------------------------------------------------------------------
//----------------------------------------------------------------------------
package cio_pkg;

  // Sizes of the block.
  localparam int unsigned APB_AW   = 8;
  localparam int unsigned NUM_IN   = 4;
  localparam int unsigned NUM_ALM  = 16;
  localparam int unsigned NUM_RLY  = 4;
  localparam int unsigned NUM_EV   = 3;
  localparam int unsigned CODE_W   = 13;
  localparam int unsigned CNT_W    = 23;

  // Contact input indices inside the filtered level vector.
  localparam int unsigned IN1  = 0;
  localparam int unsigned IN2  = 1;
  localparam int unsigned IN3  = 2;
  localparam int unsigned IN16 = 3;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_POL       = 8'h04;
  localparam logic [7:0] OFS_LATCH_EN  = 8'h08;
  localparam logic [7:0] OFS_DEENERG   = 8'h0C;
  localparam logic [7:0] OFS_SEL_BASE  = 8'h10;
  localparam logic [7:0] OFS_LATCH_REL = 8'h20;
  localparam logic [7:0] OFS_FUNC_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h28;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h2C;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h30;
  localparam logic [7:0] OFS_ALM_STAT  = 8'h34;

  // Field positions.
  localparam int unsigned CTRL_ORCTL_BIT = 3;
  localparam int unsigned EV_FUNC        = 0;
  localparam int unsigned EV_EDGE        = 1;
  localparam int unsigned EV_RELAY       = 2;

  // Operating modes of the controller.
  typedef enum logic [2:0] {
    MODE_SINGLE, MODE_PV_HOLD, MODE_CAS_PRI, MODE_BACKUP,
    MODE_CAS_SEC, MODE_CASCADE, MODE_PV_SWITCH, MODE_PV_AUTOSEL
  } cio_mode_e;

  // Cascade-mode loop state.
  typedef enum logic [1:0] {CAS_ST_CAS, CAS_ST_AUTO, CAS_ST_MAN} cio_cas_e;

  // Reset values.
  localparam logic [3:0]  POL_RST  = 4'h0;
  localparam logic [15:0] ALM_RST  = 16'h0000;
  localparam logic [12:0] SEL_RST  = 13'h1101;

  // Status selection codes (4321, 4353, span 25, loop-2 step 16).
  localparam logic [12:0] CODE_RAW_BASE = 13'h10E1;
  localparam logic [12:0] CODE_OUT_BASE = 13'h1101;
  localparam logic [12:0] CODE_SPAN     = 13'h0019;
  localparam logic [12:0] CODE_L2_OFS   = 13'h0010;

  // Timing: clock in hertz, other figures in milliseconds and derived cycle counts.
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned CONTACT_MIN_MS = 50;
  localparam int unsigned DEBOUNCE_MS    = 20;
  localparam int unsigned CTRL_PERIOD_MS = 50;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned DEBOUNCE_CYC_DFLT    = DEBOUNCE_MS * CYC_PER_MS;
  localparam int unsigned CTRL_PERIOD_CYC_DFLT = CTRL_PERIOD_MS * CYC_PER_MS;

endpackage : cio_pkg

// [shared/cio_din_if.sv]
// Interface: filtered contact levels from the input filter to the core.
interface cio_din_if;
  logic [3:0] level;  // Debounced contact state, 1 = closed.

  modport filt (output level);
  modport core (input level);
endinterface : cio_din_if

// [hdl/cio_contact_filter.sv]
// Synchroniser and debounce filter for the field contact inputs.
module cio_contact_filter #(
  parameter int unsigned DEBOUNCE_CYC = cio_pkg::DEBOUNCE_CYC_DFLT
) (
  // Clock and reset.
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Raw contact pins.
  input  wire logic [cio_pkg::NUM_IN-1:0] contact_raw,
  // Filtered levels towards the core.
  cio_din_if.filt                       din
);
  import cio_pkg::*;

  //--------------------------------------------------------------------------
  // Per-channel filter
  //--------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++) begin : g_ch
      logic [2:0]       sync_r;  // Stage 0 is read only by stage 1.
      logic [CNT_W-1:0] cnt_r;   // Cycles the new level has been stable.
      logic             lvl_r;   // Accepted contact level.
      wire              agree;
      wire              differ;
      wire              cnt_done;

      // A change counts only once the second and third stages agree.
      assign agree    = sync_r[1] == sync_r[2];
      assign differ   = agree && (sync_r[2] != lvl_r);
      assign cnt_done = cnt_r == CNT_W'(DEBOUNCE_CYC - 1);

      // Debounce shorter than the least pulse, so a legal pulse survives.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_r <= 3'h0;
          cnt_r  <= '0;
          lvl_r  <= 1'b0;
        end else begin
          sync_r <= {sync_r[1:0], contact_raw[g]};
          cnt_r  <= (differ && !cnt_done) ? cnt_r + 1'b1 : '0;
          if (differ && cnt_done) begin
            lvl_r <= sync_r[2];
          end
        end
      end

      assign din.level[g] = lvl_r;
    end
  endgenerate

endmodule // cio_contact_filter

// [hdl/cio_contact_io.sv]
// Contact input function map and contact output status selection.
module cio_contact_io #(
  parameter int unsigned DEBOUNCE_CYC    = cio_pkg::DEBOUNCE_CYC_DFLT,
  parameter int unsigned CTRL_PERIOD_CYC = cio_pkg::CTRL_PERIOD_CYC_DFLT
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Field contacts, high when the contact is closed.
  input  wire logic        contact_in_1,
  input  wire logic        contact_in_2,
  input  wire logic        contact_in_3,
  input  wire logic        contact_in_16,
  // Alarm engine and control output of the loop.
  input  wire logic [15:0] alarm_raw,
  input  wire logic        control_out,
  // Relay outputs, high when the contact is closed.
  output logic      [2:0]  alarm_relay,
  output logic             out_relay,
  // Operating mode functions.
  output logic             mode_auto,
  output logic             mode_stop,
  output logic             mode_remote,
  output logic             mode_track,
  output logic             mode_pv_rsp,
  output logic      [1:0]  cas_state,
  // Interrupt.
  output logic             irq
);
  import cio_pkg::*;

  //--------------------------------------------------------------------------
  // Input filtering
  //--------------------------------------------------------------------------
  cio_din_if din ();

  cio_contact_filter #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_filter (
    .pclk        (pclk),
    .presetn     (presetn),
    .contact_raw ({contact_in_16, contact_in_3, contact_in_2, contact_in_1}),
    .din         (din)
  );

  //--------------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------------
  cio_mode_e          mode_r;        // Control mode.
  logic               orctl_r;       // Control relay is the loop output.
  logic [3:0]         pol_r;         // Per-input polarity.
  logic [15:0]        latch_en_r;    // Per-alarm latch action.
  logic [15:0]        deen_r;        // Per-alarm de-energized contact.
  logic [12:0]        sel_r [4];     // Relay status selection codes.
  logic [15:0]        latch_q_r;     // Latched alarm state.
  logic [2:0]         irq_st_r;      // Sticky event bits.
  logic [2:0]         irq_en_r;      // Event enables.
  logic [CNT_W-1:0]   ctl_cnt_r;     // Control period counter.
  logic [3:0]         act_q_r;       // Active levels, last cycle.
  logic [2:0]         pend_r;        // Edges waiting for the next period.
  logic               auto_r;
  logic               stop_r;
  logic               remote_r;
  logic               track_r;
  logic               pvrsp_r;
  cio_cas_e           cas_r;
  logic [3:0]         relay_r;
  logic               irq_r;
  logic               pready_r;
  logic               pslverr_r;
  logic [31:0]        prdata_r;

  //--------------------------------------------------------------------------
  // APB decode
  //--------------------------------------------------------------------------
  wire        acc      = psel && penable && pready_r;
  wire        wr       = acc && pwrite;
  wire        hit_ctrl = paddr == OFS_CTRL;
  wire        hit_pol  = paddr == OFS_POL;
  wire        hit_len  = paddr == OFS_LATCH_EN;
  wire        hit_den  = paddr == OFS_DEENERG;
  wire        hit_sel  = (paddr[7:4] == OFS_SEL_BASE[7:4]) &&
                         (paddr[1:0] == 2'h0);
  wire        hit_rel  = paddr == OFS_LATCH_REL;
  wire        hit_fst  = paddr == OFS_FUNC_STAT;
  wire        hit_ist  = paddr == OFS_IRQ_STAT;
  wire        hit_icl  = paddr == OFS_IRQ_CLR;
  wire        hit_ien  = paddr == OFS_IRQ_EN;
  wire        hit_ast  = paddr == OFS_ALM_STAT;
  wire        mapped   = hit_ctrl | hit_pol | hit_len | hit_den | hit_sel |
                         hit_rel | hit_fst | hit_ist | hit_icl | hit_ien |
                         hit_ast;
  wire [1:0]  sel_idx  = paddr[3:2];
  wire [15:0] rel_bits = (wr && hit_rel) ? pwdata[15:0] : 16'h0000;
  wire [2:0]  clr_bits = (wr && hit_icl) ? pwdata[2:0] : 3'h0;
  wire [15:0] out_st;
  wire [31:0] rd_data;

  // Write-only registers and holes read as zero.
  assign rd_data = hit_ctrl ? {28'h0, orctl_r, mode_r} :
                   hit_pol  ? {28'h0, pol_r} :
                   hit_len  ? {16'h0, latch_en_r} :
                   hit_den  ? {16'h0, deen_r} :
                   hit_sel  ? {19'h0, sel_r[sel_idx]} :
                   hit_fst  ? {25'h0, cas_r, pvrsp_r, track_r, remote_r,
                               stop_r, auto_r} :
                   hit_ist  ? {29'h0, irq_st_r} :
                   hit_ien  ? {29'h0, irq_en_r} :
                   hit_ast  ? {out_st, alarm_raw} : 32'h0;

  // One wait state: pready rises on the second access-phase cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata_r <= rd_data;
      end
    end
  end

  // Software-written configuration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r     <= MODE_SINGLE;
      orctl_r    <= 1'b1;
      pol_r      <= POL_RST;
      latch_en_r <= ALM_RST;
      deen_r     <= ALM_RST;
      irq_en_r   <= 3'h0;
    end else if (wr) begin
      if (hit_ctrl) begin
        mode_r  <= cio_mode_e'(pwdata[2:0]);
        orctl_r <= pwdata[CTRL_ORCTL_BIT];
      end
      if (hit_pol) begin
        pol_r <= pwdata[3:0];
      end
      if (hit_len) begin
        latch_en_r <= pwdata[15:0];
      end
      if (hit_den) begin
        deen_r <= pwdata[15:0];
      end
      if (hit_ien) begin
        irq_en_r <= pwdata[2:0];
      end
    end
  end

  //--------------------------------------------------------------------------
  // Contact input functions
  //--------------------------------------------------------------------------
  wire [3:0] act       = din.level ^ pol_r;
  wire [2:0] rise      = act[2:0] & ~act_q_r[2:0];
  wire       tick      = ctl_cnt_r == CNT_W'(CTRL_PERIOD_CYC - 1);
  wire       edge_mode = (mode_r == MODE_CAS_SEC) || (mode_r == MODE_CASCADE);
  logic      auto_nxt;
  logic      stop_nxt;
  logic      remote_nxt;
  logic      track_nxt;
  logic      pvrsp_nxt;
  cio_cas_e  cas_nxt;

  // Default function table per mode; unlisted inputs have no effect.
  always_comb begin
    auto_nxt   = act[IN1];
    stop_nxt   = act[IN2];
    remote_nxt = 1'b0;
    track_nxt  = 1'b0;
    pvrsp_nxt  = 1'b0;
    cas_nxt    = cas_r;
    unique case (mode_r)
      MODE_SINGLE, MODE_PV_HOLD: begin
        remote_nxt = act[IN16];
      end
      MODE_CAS_PRI, MODE_BACKUP: begin
        track_nxt = act[IN16];
      end
      MODE_PV_SWITCH: begin
        pvrsp_nxt = act[IN16];
      end
      MODE_PV_AUTOSEL: begin
        pvrsp_nxt = 1'b0;
      end
      MODE_CAS_SEC, MODE_CASCADE: begin
        // MAN wins over AUTO over CAS if edges land in one period.
        if (pend_r[IN3]) begin
          cas_nxt = CAS_ST_MAN;
        end else if (pend_r[IN2]) begin
          cas_nxt = CAS_ST_AUTO;
        end else if (pend_r[IN1]) begin
          cas_nxt = CAS_ST_CAS;
        end
        if (mode_r == MODE_CAS_SEC && act[IN16] && cas_nxt == CAS_ST_CAS) begin
          cas_nxt = CAS_ST_AUTO;
        end
        stop_nxt = (mode_r == MODE_CASCADE) && act[IN16];
        auto_nxt = cas_nxt != CAS_ST_MAN;
      end
    endcase
  end

  wire func_chg = tick && ({auto_nxt, stop_nxt, remote_nxt, track_nxt,
                            pvrsp_nxt, cas_nxt} !=
                           {auto_r, stop_r, remote_r, track_r, pvrsp_r, cas_r});

  // Period counter; functions only change on its tick, like the loop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_cnt_r <= '0;
      act_q_r   <= 4'h0;
      pend_r    <= 3'h0;
    end else begin
      ctl_cnt_r <= tick ? '0 : ctl_cnt_r + 1'b1;
      act_q_r   <= act;
      // A new edge in the tick cycle is kept for the next period.
      pend_r    <= (pend_r & ~{3{tick}}) | (rise & {3{edge_mode}});
    end
  end

  // Mode function outputs, updated once per control period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_r   <= 1'b0;
      stop_r   <= 1'b0;
      remote_r <= 1'b0;
      track_r  <= 1'b0;
      pvrsp_r  <= 1'b0;
      cas_r    <= CAS_ST_MAN;
    end else if (tick) begin
      auto_r   <= auto_nxt;
      stop_r   <= stop_nxt;
      remote_r <= remote_nxt;
      track_r  <= track_nxt;
      pvrsp_r  <= pvrsp_nxt;
      cas_r    <= cas_nxt;
    end
  end

  //--------------------------------------------------------------------------
  // Alarm conditioning and relay selection
  //--------------------------------------------------------------------------
  // Raw status passes untouched; output status carries latch and contact type.
  assign out_st = (alarm_raw | (latch_q_r & latch_en_r)) ^ deen_r;

  // Map a selection code to one status bit; unknown codes give an open relay.
  function automatic logic sel_bit(input logic [12:0] code,
                                   input logic [15:0] raw,
                                   input logic [15:0] ost,
                                   input logic        l2_ok);
    logic [12:0] off_r;
    logic [12:0] off_o;
    logic [12:0] off;
    logic        is_raw;
    logic        is_out;
    logic [3:0]  pos;
    logic [3:0]  bitno;
    logic        ok;
    begin
      off_r  = code - CODE_RAW_BASE;
      off_o  = code - CODE_OUT_BASE;
      is_raw = (code >= CODE_RAW_BASE) && (off_r <= CODE_SPAN);
      is_out = (code >= CODE_OUT_BASE) && (off_o <= CODE_SPAN);
      off    = is_raw ? off_r : off_o;
      pos    = 4'(off[3:2]) * 4'h3 + 4'(off[1:0]);
      bitno  = {off[4], pos[2:0]};
      ok     = (is_raw || is_out) && (off[1:0] != 2'h3) && (pos < 4'h8) &&
               (!off[4] || l2_ok);
      sel_bit = ok && (is_raw ? raw[bitno] : ost[bitno]);
    end
  endfunction

  logic [3:0] sel_hit;
  wire        l2_ok = mode_r == MODE_CASCADE;

  // Each relay has its own selection register and status lookup.
  genvar r;
  generate
    for (r = 0; r < NUM_RLY; r++) begin : g_rly
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sel_r[r] <= SEL_RST;
        end else if (wr && hit_sel && sel_idx == 2'(r)) begin
          sel_r[r] <= pwdata[12:0];
        end
      end
      assign sel_hit[r] = sel_bit(sel_r[r], alarm_raw, out_st, l2_ok);
    end
  endgenerate

  // The control relay follows the loop output while it controls.
  wire [3:0] relay_nxt = {orctl_r ? control_out : sel_hit[3],
                          sel_hit[2:0]};

  // Energized contact closes on the selected event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_r   <= 4'h0;
      latch_q_r <= ALM_RST;
    end else begin
      relay_r   <= relay_nxt;
      latch_q_r <= (latch_q_r & ~rel_bits) | (alarm_raw & latch_en_r);
    end
  end

  //--------------------------------------------------------------------------
  // Interrupts
  //--------------------------------------------------------------------------
  wire [2:0] ev = {relay_nxt != relay_r, |(rise & {3{edge_mode}}), func_chg};

  // Sticky status; an event in the clear cycle still sets its bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_r <= 3'h0;
      irq_r    <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~clr_bits) | ev;
      irq_r    <= |(((irq_st_r & ~clr_bits) | ev) & irq_en_r);
    end
  end

  //--------------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------------
  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign alarm_relay = relay_r[2:0];
  assign out_relay   = relay_r[3];
  assign mode_auto   = auto_r;
  assign mode_stop   = stop_r;
  assign mode_remote = remote_r;
  assign mode_track  = track_r;
  assign mode_pv_rsp = pvrsp_r;
  assign cas_state   = cas_r;
  assign irq         = irq_r;

  //--------------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SINGLE_DEFAULTS: assert property (
    tick && (mode_r == MODE_SINGLE || mode_r == MODE_PV_HOLD) |=>
      auto_r == $past(act[IN1]) && stop_r == $past(act[IN2]) &&
      remote_r == $past(act[IN16]) && !track_r)
    else $error("single-loop defaults wrong");
  AST_PRIMARY_TRACK: assert property (
    tick && (mode_r == MODE_CAS_PRI || mode_r == MODE_BACKUP) |=>
      track_r == $past(act[IN16]) && !remote_r)
    else $error("tracking input wrong");
  AST_PV_SWITCH: assert property (
    tick && mode_r == MODE_PV_SWITCH |=> pvrsp_r == $past(act[IN16]))
    else $error("PV switch input wrong");
  AST_AUTOSEL_NONE: assert property (
    tick && mode_r == MODE_PV_AUTOSEL |=> !remote_r && !track_r && !pvrsp_r)
    else $error("auto-selector input 16 acted");
  AST_IN3_UNUSED: assert property (
    tick && !edge_mode |=> $stable(cas_r))
    else $error("input 3 acted outside cascade modes");
  AST_CAS_MAN_EDGE: assert property (
    tick && edge_mode && pend_r[IN3] |=> cas_r == CAS_ST_MAN && !auto_r)
    else $error("MAN edge not taken");
  AST_POLARITY: assert property (
    tick && mode_r == MODE_SINGLE && (din.level[IN1] != pol_r[IN1]) |=> auto_r)
    else $error("polarity not applied");
  AST_PEND_HOLD: assert property (
    edge_mode && rise[IN1] ##1 !tick [*2] |-> pend_r[IN1])
    else $error("edge lost before period tick");
  AST_RELAY_RAW: assert property (
    sel_r[0] == CODE_RAW_BASE |=> alarm_relay[0] == $past(alarm_raw[0]))
    else $error("raw alarm 1 not on relay 1");
  AST_RELAY_OUT: assert property (
    sel_r[1] == CODE_OUT_BASE && !deen_r[0] && !latch_en_r[0] |=>
      alarm_relay[1] == $past(alarm_raw[0]))
    else $error("energized output status wrong");
  AST_LOOP2_GATE: assert property (
    sel_r[2] == CODE_RAW_BASE + CODE_L2_OFS && !l2_ok |=> !alarm_relay[2])
    else $error("loop-2 alarm outside cascade");
  AST_LATCH: assert property (
    latch_en_r[3] && alarm_raw[3] |=> latch_q_r[3] ##1
      (latch_q_r[3] || $past(rel_bits[3])))
    else $error("latch did not hold");
  AST_OR_CONTROL: assert property (
    orctl_r |=> out_relay == $past(control_out))
    else $error("control relay not following loop");

  COV_CAS_EDGE: cover property (tick && edge_mode && pend_r[IN1]);
  COV_FAIL_FORCE: cover property (tick && mode_r == MODE_CAS_SEC &&
                                  act[IN16] && pend_r[IN1]);
  COV_OUT_RELAY: cover property (!orctl_r && out_relay);
  COV_IRQ: cover property (irq && $past(!irq));

endmodule // cio_contact_io

// [bench/cio_field_model.sv]
// Field contact model: switches seen by the contact inputs.
module cio_field_model (
  // Clock of the sampling side.
  input  wire logic       pclk,
  // Wanted contact state, 1 = closed.
  input  wire logic [3:0] want,
  // Contact pins towards the block.
  output logic      [3:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // A switch moves only at an edge, then stands far past the filter span.
  always_ff @(posedge pclk) begin
    pin <= want;
  end
endmodule // cio_field_model

// [bench/cio_contact_io_bench.sv]
// Testbench of the contact input function map and relay selection.
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
  fail_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module cio_contact_io_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ctl, orl, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] alm;
  logic [3:0]  want, pin;
  logic [2:0]  arl;
  logic        m_auto, m_stop, m_rem, m_trk, m_rsp;
  logic        irq;
  logic [1:0]  cas;
  int          fail_count, n_compared;
  cio_field_model cio_field_model_i (.pclk(pclk), .want(want), .pin(pin));
  cio_contact_io #(.DEBOUNCE_CYC(4), .CTRL_PERIOD_CYC(16)) cio_contact_io_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .contact_in_1(pin[0]),
    .contact_in_2(pin[1]), .contact_in_3(pin[2]), .contact_in_16(pin[3]),
    .alarm_raw(alm), .control_out(ctl), .alarm_relay(arl), .out_relay(orl),
    .mode_auto(m_auto), .mode_stop(m_stop), .mode_remote(m_rem),
    .mode_track(m_trk), .mode_pv_rsp(m_rsp), .cas_state(cas), .irq(irq));
  task automatic close_out();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (i == 19) begin fail_count++; close_out(); end
    end
    q = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Lets a contact change pass filter and one control tick.
  task automatic settle();
    repeat (30) @(posedge pclk);
  endtask
  task automatic t_reset_regs();
    apb(0, 8'h00, 32'h0); `CHK("ctrl", 32'h00000008, q)
    apb(0, 8'h10, 32'h0); `CHK("sel1", 32'h00001101, q)
    apb(0, 8'h40, 32'h0); `CHK("unmapped", 1'b1, err)
  endtask
  task automatic t_single();
    apb(1, 8'h00, 32'h9);  // PV-hold mode shares the single-loop table.
    want <= 4'hD; settle();  // In1, in3, in16 closed.
    `CHK("auto", 1'b1, m_auto)
    `CHK("remote", 1'b1, m_rem)
    `CHK("stop", 1'b0, m_stop)
    apb(1, 8'h04, 32'h1); settle();
    `CHK("auto open", 1'b0, m_auto)
    apb(1, 8'h04, 32'h0);
  endtask
  task automatic t_pv_switch();
    apb(1, 8'h00, 32'hE); settle();
    `CHK("pv rsp", 1'b1, m_rsp)
    `CHK("remote off", 1'b0, m_rem)
  endtask
  // Auto-selector, primary and backup tables; control relay kept on.
  task automatic t_modes();
    apb(1, 8'h00, 32'hF); settle();
    `CHK("autosel rsp", 1'b0, m_rsp)
    `CHK("autosel trk", 1'b0, m_trk)
    apb(1, 8'h00, 32'hA); settle();
    `CHK("track", 1'b1, m_trk)
    `CHK("remote idle", 1'b0, m_rem)
    apb(1, 8'h00, 32'hB); apb(1, 8'h04, 32'h8); settle();
    `CHK("track open", 1'b0, m_trk)
    apb(1, 8'h04, 32'h0);
  endtask
  task automatic t_relays();
    apb(1, 8'h10, 32'h10E1); apb(1, 8'h14, 32'h10E4);
    alm <= 16'hFFFF; ctl <= 1'b1; repeat (3) @(posedge pclk);
    `CHK("raw relay", 1'b1, arl[0])
    `CHK("gap code", 1'b0, arl[1])
    `CHK("ctl relay", 1'b1, orl)
    apb(1, 8'h00, 32'h0); alm <= 16'h0000; repeat (3) @(posedge pclk);
    `CHK("status relay", 1'b0, orl)
    `CHK("raw off", 1'b0, arl[0])
    apb(1, 8'h0C, 32'h1); apb(1, 8'h08, 32'h8); apb(1, 8'h18, 32'h10F1);
    apb(1, 8'h10, 32'h1105);
    apb(1, 8'h14, 32'h1101);
    alm <= 16'h0108; @(posedge pclk); alm <= 16'h0100;
    repeat (3) @(posedge pclk);
    `CHK("deenergized", 1'b1, arl[1])
    `CHK("latched", 1'b1, arl[0])
    `CHK("loop-2 gated", 1'b0, arl[2])
    apb(1, 8'h20, 32'h8); repeat (2) @(posedge pclk);
    `CHK("released", 1'b0, arl[0])
  endtask
  // Edge-switched cascade states, the FAIL override and the edge interrupt.
  task automatic t_cascade();
    apb(1, 8'h30, 32'h2); apb(1, 8'h00, 32'h5); settle();
    `CHK("cas stop", 1'b1, m_stop)
    `CHK("loop-2 cascade", 1'b1, arl[2])
    `CHK("cas idle", 2'h2, cas)
    want <= 4'h8; settle(); want <= 4'h9; settle();
    `CHK("to cas", 2'h0, cas)
    `CHK("cas auto", 1'b1, m_auto)
    `CHK("edge irq", 1'b1, irq)
    want <= 4'hD; settle();
    `CHK("to man", 2'h2, cas)
    apb(0, 8'h28, 32'h0); `CHK("edge stat", 1'b1, q[1])
    apb(1, 8'h2C, 32'h7); repeat (2) @(posedge pclk);
    `CHK("irq clear", 1'b0, irq)
    apb(1, 8'h00, 32'h4); want <= 4'h8; settle(); want <= 4'h9; settle();
    `CHK("fail auto", 2'h1, cas)
    `CHK("sec stop", 1'b0, m_stop)
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; alm = 16'h0000; ctl = 1'b0; want = 4'h0;
    fail_count = 0; n_compared = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_regs(); t_single(); t_pv_switch(); t_modes(); t_relays();
    t_cascade();
    close_out();
  end
endmodule // cio_contact_io_bench
